// file: verilog/rtca_config.sv
// RTC interval and alarm configuration register with its interval timer.
// Assumes SFR strobes, tick strobes and calendar match inputs are synchronous.
// Assumes the interval count value arrives as a level from the indirect path.
`include "rtca_params.svh"

module rtca_config
    import rtca_pkg::*;
#(
    parameter int CW = `RTCA_COUNT_WIDTH,
    parameter int NF = `RTCA_ALARM_FIELDS
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    output logic [7:0] sfrRdData,
    input wire logic [CW-1:0] intervalCountTarget,
    input wire logic [NF-1:0] alarmFieldEnable,
    input wire logic [NF-1:0] alarmFieldMatch,
    input wire logic rtcIrqEnable,
    input wire logic tick128,
    input wire logic tickSec,
    input wire logic tickMin,
    input wire logic tickHour,
    output logic alarmMatchFlag,
    output logic intervalElapsedFlag,
    output logic rtcIrq
);

    // ****************************************
    // Constants
    // ****************************************
    localparam logic [7:0] CfgAddr = `RTCA_CONFIG_ADDR;
    localparam logic [7:0] CfgReset = `RTCA_CONFIG_RESET;
    localparam logic [NF-1:0] AllFields = {NF{1'b1}};

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic enable;
        logic single;
        logic [1:0] sel;
        logic alarmFlag;
        logic intervalFlag;
        logic actEnable;
        logic actSingle;
        logic [1:0] actSel;
        logic [CW-1:0] actTarget;
        logic matchPrev;
        logic [7:0] rdData;
        logic irq;
    } rtca_cfg_s;

    rtca_cfg_s s_q;
    rtca_cfg_s s_d;
    rtca_cfg_s resetState;
    logic addrHit;
    logic cfgWrite;
    logic cfgRead;
    logic wrEnable;
    logic wrSingle;
    logic [1:0] wrSel;
    logic wrKeepAlarm;
    logic wrKeepInterval;
    logic [NF-1:0] fieldOk;
    logic anyEnabled;
    logic alarmMatch;
    logic alarmRise;
    logic intervalDone;
    logic transfer;
    logic [7:0] regValue;

    // ****************************************
    // Carrier to the interval timer
    // ****************************************
    rtca_timer_if #(.CW(CW)) timerBus ();

    // ****************************************
    // Register decode
    // ****************************************
    assign addrHit = (sfrAddr == CfgAddr);
    assign cfgWrite = sfrWrEn && addrHit;
    assign cfgRead = sfrRdEn && addrHit;
    // Bits 7 and 0 never reach the register
    assign wrEnable = sfrWrData[`RTCA_BIT_ENABLE];
    assign wrSingle = sfrWrData[`RTCA_BIT_SINGLE];
    assign wrSel = sfrWrData[`RTCA_BIT_SEL_HI:`RTCA_BIT_SEL_LO];
    // Flags clear on a written 0 only
    assign wrKeepAlarm = sfrWrData[`RTCA_BIT_ALARM_FLAG];
    assign wrKeepInterval = sfrWrData[`RTCA_BIT_INTERVAL_FLAG];

    // ****************************************
    // Alarm compare
    // ****************************************
    for (genvar f = 0; f < NF; f++) begin : g_field
        // A disabled field counts as matching
        assign fieldOk[f] = alarmFieldMatch[f] || !alarmFieldEnable[f];
    end
    // No field enabled means no alarm at all
    assign anyEnabled = |alarmFieldEnable;
    assign alarmMatch = anyEnabled && (fieldOk == AllFields);
    // Edge qualified: a held match cannot set the flag again
    assign alarmRise = alarmMatch && !s_q.matchPrev;

    // ****************************************
    // Timer events
    // ****************************************
    assign intervalDone = timerBus.elapsed;
    // Settings move to the timer only on the 128 Hz tick
    assign transfer = tick128;

    // ****************************************
    // Read back
    // ****************************************
    // Shows the written settings, not the copy in use
    always_comb begin
        regValue = 8'h00;
        regValue[`RTCA_BIT_ALARM_FLAG] = s_q.alarmFlag;
        regValue[`RTCA_BIT_SEL_HI:`RTCA_BIT_SEL_LO] = s_q.sel;
        regValue[`RTCA_BIT_SINGLE] = s_q.single;
        regValue[`RTCA_BIT_INTERVAL_FLAG] = s_q.intervalFlag;
        regValue[`RTCA_BIT_ENABLE] = s_q.enable;
    end

    // ****************************************
    // Reset value
    // ****************************************
    always_comb begin
        resetState = '0;
        resetState.enable = CfgReset[`RTCA_BIT_ENABLE];
        resetState.single = CfgReset[`RTCA_BIT_SINGLE];
        resetState.sel = CfgReset[`RTCA_BIT_SEL_HI:`RTCA_BIT_SEL_LO];
        resetState.alarmFlag = CfgReset[`RTCA_BIT_ALARM_FLAG];
        resetState.intervalFlag = CfgReset[`RTCA_BIT_INTERVAL_FLAG];
        // Timer copy starts equal to the register
        resetState.actEnable = CfgReset[`RTCA_BIT_ENABLE];
        resetState.actSingle = CfgReset[`RTCA_BIT_SINGLE];
        resetState.actSel = CfgReset[`RTCA_BIT_SEL_HI:`RTCA_BIT_SEL_LO];
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.matchPrev = alarmMatch;
        if (cfgWrite) begin
            s_d.enable = wrEnable;
            s_d.single = wrSingle;
            s_d.sel = wrSel;
            if (!wrKeepAlarm) begin
                s_d.alarmFlag = 1'b0;
            end
            if (!wrKeepInterval) begin
                s_d.intervalFlag = 1'b0;
            end
        end
        // Set wins over a same-cycle clear
        if (alarmRise) begin
            s_d.alarmFlag = 1'b1;
        end
        if (intervalDone) begin
            s_d.intervalFlag = 1'b1;
        end
        if (transfer) begin
            s_d.actEnable = s_d.enable;
            s_d.actSingle = s_d.single;
            s_d.actSel = s_d.sel;
            s_d.actTarget = intervalCountTarget;
        end
        s_d.rdData = cfgRead ? regValue : 8'h00;
        // Interrupt follows the flag and its enable
        s_d.irq = s_d.alarmFlag && rtcIrqEnable;
    end

    // ****************************************
    // Register
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= resetState;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Timer settings
    // ****************************************
    assign timerBus.enable = s_q.actEnable;
    assign timerBus.single = s_q.actSingle;
    assign timerBus.sel = s_q.actSel;
    assign timerBus.target = s_q.actTarget;

    // ****************************************
    // Timebase ticks
    // ****************************************
    assign timerBus.tick128 = tick128;
    assign timerBus.tickSec = tickSec;
    assign timerBus.tickMin = tickMin;
    assign timerBus.tickHour = tickHour;

    // ****************************************
    // Interval timer
    // ****************************************
    rtca_interval_timer #(.CW(CW)) intervalTimer (
        .clock(clock),
        .srst(srst),
        .tmr(timerBus)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign sfrRdData = s_q.rdData;
    assign alarmMatchFlag = s_q.alarmFlag;
    assign intervalElapsedFlag = s_q.intervalFlag;
    assign rtcIrq = s_q.irq;

endmodule // rtca_config

// file: verilog/rtca_params.svh
// Constants for the RTC interval timer and alarm flag configuration block.
// Assumes a single 200 MHz clock and synchronous tick strobes from the RTC.
`ifndef RTCA_PARAMS_SVH
`define RTCA_PARAMS_SVH

`define RTCA_CONFIG_ADDR 8'ha1
`define RTCA_CONFIG_RESET 8'h00
`define RTCA_BIT_ALARM_FLAG 6
`define RTCA_BIT_SEL_HI 5
`define RTCA_BIT_SEL_LO 4
`define RTCA_BIT_SINGLE 3
`define RTCA_BIT_INTERVAL_FLAG 2
`define RTCA_BIT_ENABLE 1
`define RTCA_ALARM_FIELDS 5
`define RTCA_COUNT_WIDTH 8

`endif

// file: verilog/rtca_pkg.sv
// Types for the RTC interval timer and alarm flag configuration block.
// Assumes rtca_params.svh is included by the users of the constants.
package rtca_pkg;

    typedef enum logic [1:0] {
        RTCA_TB_128HZ = 2'b00,
        RTCA_TB_SEC = 2'b01,
        RTCA_TB_MIN = 2'b10,
        RTCA_TB_HOUR = 2'b11
    } rtca_timebase_e;

    typedef enum logic [1:0] {
        RTCA_IDLE = 2'b00,
        RTCA_RUN = 2'b01,
        RTCA_DONE = 2'b10
    } rtca_timer_state_e;

endpackage

// file: verilog/rtca_timer_if.sv
// Carrier between the configuration logic and the interval timer.
// Assumes both ends sit on the same clock.
interface rtca_timer_if #(
    parameter int CW = 8
);
    logic enable;
    logic single;
    logic [1:0] sel;
    logic [CW-1:0] target;
    logic tick128;
    logic tickSec;
    logic tickMin;
    logic tickHour;
    logic elapsed;

    modport cfg (
        output enable, single, sel, target, tick128, tickSec, tickMin, tickHour,
        input elapsed
    );
    modport tmr (
        input enable, single, sel, target, tick128, tickSec, tickMin, tickHour,
        output elapsed
    );
endinterface

// file: verilog/rtca_interval_timer.sv
// Interval timer: counts ticks of the selected timebase against a target.
// Assumes tick strobes are single-cycle pulses on the block clock.
module rtca_interval_timer
    import rtca_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic clock,
    input wire logic srst,
    rtca_timer_if.tmr tmr
);

    typedef struct packed {
        rtca_timer_state_e state;
        logic [CW-1:0] count;
        logic elapsed;
    } rtca_tmr_s;

    rtca_tmr_s s_q;
    rtca_tmr_s s_d;
    logic tick;
    logic [CW-1:0] nextCount;

    always_comb begin
        unique case (rtca_timebase_e'(tmr.sel))
            RTCA_TB_128HZ: tick = tmr.tick128;
            RTCA_TB_SEC: tick = tmr.tickSec;
            RTCA_TB_MIN: tick = tmr.tickMin;
            RTCA_TB_HOUR: tick = tmr.tickHour;
        endcase
    end

    assign nextCount = s_q.count + {{(CW-1){1'b0}}, 1'b1};

    always_comb begin
        s_d = s_q;
        s_d.elapsed = 1'b0;
        unique case (s_q.state)
            RTCA_IDLE: begin
                s_d.count = '0;
                if (tmr.enable) begin
                    s_d.state = RTCA_RUN;
                end
            end
            RTCA_RUN: begin
                if (tick) begin
                    if (nextCount == tmr.target) begin
                        s_d.elapsed = 1'b1;
                        s_d.count = '0;
                        if (tmr.single) begin
                            s_d.state = RTCA_DONE;
                        end // else next interval starts at once
                    end else begin
                        s_d.count = nextCount;
                    end
                end
            end
            RTCA_DONE: begin
                s_d.count = '0;
                if (!tmr.single) begin
                    s_d.state = RTCA_RUN;
                end
            end
            default: begin
                s_d.state = RTCA_IDLE;
            end
        endcase
        if (!tmr.enable) begin
            s_d.state = RTCA_IDLE;
            s_d.count = '0;
            s_d.elapsed = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '{state: RTCA_IDLE, count: '0, elapsed: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign tmr.elapsed = s_q.elapsed;

endmodule // rtca_interval_timer

// file: verification/rtca_config_chk.sv
// Checker for the RTC interval and alarm config block.
// Assumes a bind onto rtca_config; one clock, sync reset.
// ********
// Checker
// ********
module rtca_config_chk #(
    parameter int NF = 5
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrRdData,
    input wire logic [NF-1:0] alarmFieldEnable,
    input wire logic [NF-1:0] alarmFieldMatch,
    input wire logic rtcIrqEnable,
    input wire logic tick128,
    input wire logic tickSec,
    input wire logic tickMin,
    input wire logic tickHour,
    input wire logic alarmMatchFlag,
    input wire logic intervalElapsedFlag,
    input wire logic rtcIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire hit = |alarmFieldEnable && (alarmFieldMatch & alarmFieldEnable) == alarmFieldEnable;
    wire tk = tick128 | tickSec | tickMin | tickHour;
    wire cw = sfrWrEn && sfrAddr == 8'ha1;
    sequence hitRise;
        $rose(hit);
    endsequence
    al_set_a: assert property (hitRise |=> alarmMatchFlag)
        else $error("alarm flag not set");
    al_hold_a: assert property (!alarmMatchFlag && !$rose(hit) |=> !alarmMatchFlag)
        else $error("alarm flag set alone");
    al_clr_a: assert property (cw && !sfrWrData[6] && !$rose(hit) |=> !alarmMatchFlag)
        else $error("alarm flag not cleared");
    irq_out_a: assert property (
        rtcIrq == (alarmMatchFlag && $past(rtcIrqEnable)))
        else $error("irq wrong");
    rd_resv_a: assert property (sfrRdEn |=> !sfrRdData[7] && !sfrRdData[0])
        else $error("unused bits nonzero");
    rd_flag_a: assert property (sfrRdEn && sfrAddr == 8'ha1 |=>
        sfrRdData[6] == $past(alarmMatchFlag) && sfrRdData[2] == $past(intervalElapsedFlag))
        else $error("flag readback wrong");
    it_tick_a: assert property ($rose(intervalElapsedFlag) |-> $past(tk, 2))
        else $error("interval flag without tick");
    it_clr_a: assert property (cw && !sfrWrData[2] && !$past(tk) |=> !intervalElapsedFlag)
        else $error("interval flag not cleared");
endmodule // rtca_config_chk

// file: verification/rtca_config_tb.sv
// Bench for the RTC interval and alarm config block.
// Assumes rtca_config and its checker are compiled first.
// ********
// Bench
// ********
module rtca_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, intervalCountTarget = 8'h01;
    logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, rtcIrqEnable = 1'b0;
    logic [4:0] alarmFieldEnable = 5'h00, alarmFieldMatch = 5'h00;
    logic [3:0] tick = 4'h0;
    logic alarmMatchFlag, intervalElapsedFlag, rtcIrq;
    logic [7:0] cfg;
    int errTotal = 0;
    int nCompared = 0;
    int tgt, e;
    rtca_config DUT (
        .clock, .srst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
        .intervalCountTarget, .alarmFieldEnable, .alarmFieldMatch, .rtcIrqEnable,
        .tick128(tick[0]), .tickSec(tick[1]), .tickMin(tick[2]), .tickHour(tick[3]),
        .alarmMatchFlag, .intervalElapsedFlag, .rtcIrq
    );
    initial forever #2.5 clock = ~clock;
    task automatic chk8(logic [7:0] got, logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %0t read %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk1(logic got, logic exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %0t flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrEn <= 1'b1;
        @(posedge clock);
        sfrWrEn <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clock);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clock);
        sfrRdEn <= 1'b0;
        #1 chk8(sfrRdData, exp);
    endtask
    // One tick, then wait out the flag latency
    task automatic pulse(int s);
        @(posedge clock);
        tick <= 4'(1 << s);
        @(posedge clock);
        tick <= 4'h0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic completeRun;
        $display("Compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        errTotal++;
        $display("ERROR %0t run timed out", $time);
        completeRun();
    end
    initial begin
        e = $urandom(32'h94a1b8e9);
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd(8'ha1, 8'h00);
        wr(8'ha1, 8'hff);
        rd(8'ha1, 8'h3a);
        rd(8'ha3, 8'h00);
        wr(8'ha1, 8'h00);
        pulse(0);
        $display("Register test done");
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                tgt = 1 + $urandom % 4;
                cfg = 8'h02 | 8'(m << 3) | 8'(s << 4);
                @(posedge clock);
                intervalCountTarget <= 8'(tgt);
                wr(8'ha1, cfg);
                pulse(0);
                for (int r = 0; r < 2; r++) begin
                    for (int i = 1; i <= tgt; i++) begin
                        pulse(s);
                        chk1(intervalElapsedFlag, i == tgt && (r == 0 || m == 0));
                    end
                    wr(8'ha1, cfg);
                    rd(8'ha1, cfg);
                end
                wr(8'ha1, 8'h00);
                pulse(0);
            end
        end
        $display("Interval test done");
        @(posedge clock);
        intervalCountTarget <= 8'h03;
        wr(8'ha1, 8'h12);
        pulse(0);
        repeat (2) pulse(1);
        wr(8'ha1, 8'h00);
        pulse(0);
        repeat (4) pulse(1);
        chk1(intervalElapsedFlag, 1'b0);
        wr(8'ha1, 8'h12);
        pulse(0);
        repeat (2) pulse(1);
        chk1(intervalElapsedFlag, 1'b0);
        pulse(1);
        chk1(intervalElapsedFlag, 1'b1);
        wr(8'ha1, 8'h00);
        $display("Enable test done");
        for (int k = 0; k < 4; k++) begin
            e = 1 + $urandom % 31;
            @(posedge clock);
            alarmFieldEnable <= 5'(e);
            alarmFieldMatch <= 5'(e & (e - 1));
            rtcIrqEnable <= k[0];
            repeat (3) @(posedge clock);
            #1 chk1(alarmMatchFlag, 1'b0);
            @(posedge clock);
            alarmFieldMatch <= 5'(e);
            repeat (3) @(posedge clock);
            #1 chk1(alarmMatchFlag, 1'b1);
            chk1(rtcIrq, k[0]);
            rd(8'ha1, 8'h40);
            wr(8'ha1, 8'h00);
            repeat (3) @(posedge clock);
            #1 chk1(alarmMatchFlag, 1'b0);
            @(posedge clock);
            alarmFieldMatch <= 5'h00;
        end
        $display("Alarm test done");
        completeRun();
    end
endmodule // rtca_config_tb
bind rtca_config rtca_config_chk #(.NF(NF)) chk (
    .clock, .srst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
    .alarmFieldEnable, .alarmFieldMatch, .rtcIrqEnable, .tick128, .tickSec,
    .tickMin, .tickHour, .alarmMatchFlag, .intervalElapsedFlag, .rtcIrq
);
